// ---- rtl/bitfield_pkg.sv ----
// Constants shared by the bit-field test-and-modify engine.
// Assumes a 16-bit data path and a 32-bit classic Wishbone register bus.
package bitfield_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int REGSEL_W = 5;
  localparam int WB_ADDR_W = 8;

  // Register byte offsets.
  localparam logic [WB_ADDR_W-1:0] CMD_OFS    = 8'h00;
  localparam logic [WB_ADDR_W-1:0] MASK_OFS   = 8'h04;
  localparam logic [WB_ADDR_W-1:0] ADDR_OFS   = 8'h08;
  localparam logic [WB_ADDR_W-1:0] STATUS_OFS = 8'h0C;
  localparam logic [WB_ADDR_W-1:0] STATE_OFS  = 8'h10;

  // Command register fields.
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_SET_BIT  = 3;
  localparam int CMD_GO_BIT   = 4;
  localparam int CMD_SEL_LSB  = 5;

  // Engine state register fields.
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_ILLEGAL_BIT = 1;
  localparam int ST_DONE_BIT    = 2;
  localparam int ST_CYC_LSB     = 4;
  localparam int ST_WORDS_LSB   = 8;
  localparam int ST_DATA_LSB    = 16;

  // Status word flag positions.
  localparam int CARRY_BIT = 0;
  localparam int LIMIT_BIT = 6;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;

  // Register operand code of the hardware loop stack; value is arbitrary.
  localparam logic [REGSEL_W-1:0] HW_LOOP_STACK_SEL = 5'h1F;

  localparam logic [ADDR_W-1:0] IO_REGION_BASE = 16'hFFC0;
  localparam int SHORT_ADDR_W = 6;

  // Execution cost in cycles and words.
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_LONG  = 4'h6;
  localparam logic [1:0] WORDS_TWO = 2'h2;
  localparam logic [1:0] WORDS_THREE = 2'h3;
  // Read issue, capture and write-back cycles that are not stall cycles.
  localparam logic [3:0] CYC_FIXED = 4'h3;

  typedef enum logic [2:0] {
    MODE_ANY_REGISTER_OPERAND = 3'b000,
    MODE_SHORT_ABSOLUTE       = 3'b001,
    MODE_SHORT_IO             = 3'b010,
    MODE_POINTER_INDEXED      = 3'b011,
    MODE_STACK_RELATIVE       = 3'b100,
    MODE_LONG_ABSOLUTE        = 3'b101
  } dest_mode_t;

  typedef enum logic [2:0] {
    ENG_IDLE    = 3'b000,
    ENG_READ    = 3'b001,
    ENG_CAPTURE = 3'b010,
    ENG_STALL   = 3'b011,
    ENG_WRITE   = 3'b100
  } eng_state_t;

endpackage

// ---- rtl/bitfield_test_and_modify.sv ----
// Test-and-clear / test-and-set bit-field engine with a Wishbone register file.
// Assumes data memory, peripheral space and the core register file answer a read
// combinationally, within the cycle the read strobe is high, all on sys_clk_i.
//
// The Wishbone interface to the registers and the address map were decided locally.
module bitfield_test_and_modify
  import bitfield_pkg::*;
(
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [bitfield_pkg::WB_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  input  wire logic [bitfield_pkg::ADDR_W-1:0] index_ptr_i,
  input  wire logic [bitfield_pkg::ADDR_W-1:0] stack_ptr_i,
  output logic      [bitfield_pkg::ADDR_W-1:0] mem_addr_o,
  output logic                                mem_rd_o,
  output logic                                mem_wr_o,
  output logic      [bitfield_pkg::DATA_W-1:0] mem_wdata_o,
  input  wire logic [bitfield_pkg::DATA_W-1:0] mem_rdata_i,
  output logic      [bitfield_pkg::REGSEL_W-1:0] rf_sel_o,
  output logic                                rf_rd_o,
  output logic                                rf_wr_o,
  output logic      [bitfield_pkg::DATA_W-1:0] rf_wdata_o,
  input  wire logic [bitfield_pkg::DATA_W-1:0] rf_rdata_i,
  input  wire logic                           rf_limited_i
);
  import bitfield_pkg::*;

  typedef struct packed {
    logic                ack;
    logic [31:0]         rdata;
    dest_mode_t          mode;
    logic                set_variant;
    logic [REGSEL_W-1:0] sel;
    logic [DATA_W-1:0]   mask;
    logic [ADDR_W-1:0]   addr_field;
    logic [DATA_W-1:0]   status_word;
    eng_state_t          eng;
    logic [3:0]          stall_left;
    logic [3:0]          cost_cycles;
    logic [1:0]          cost_words;
    logic                illegal;
    logic                done;
    logic [ADDR_W-1:0]   dest_addr;
    logic [DATA_W-1:0]   result;
    logic                carry;
    logic                limited;
    logic                mem_rd;
    logic                mem_wr;
    logic                rf_rd;
    logic                rf_wr;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // True when every selected bit is one; an empty mask counts as all ones.
  function automatic logic field_all_ones(input logic [DATA_W-1:0] data,
                                          input logic [DATA_W-1:0] mask);
    field_all_ones = &(data | ~mask);
  endfunction

  function automatic logic [DATA_W-1:0] field_modify(input logic [DATA_W-1:0] data,
                                                     input logic [DATA_W-1:0] mask,
                                                     input logic              set_v);
    if (set_v) begin
      field_modify = data | mask;
    end else begin
      field_modify = data & ~mask;
    end
  endfunction

  // Byte-lane merge of a Wishbone write into a narrower register.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction

  logic              req;
  logic              legal_mode;
  logic              is_long;
  logic [ADDR_W-1:0] eff_addr;
  logic [DATA_W-1:0] operand;
  logic [31:0]       wmerge;
  logic [31:0]       state_word;

  always_comb begin
    state_next = state_reg;
    req = wb_cyc_i & wb_stb_i;
    wmerge = 32'h0000_0000;

    // Effective destination address for the memory modes.
    unique case (state_reg.mode)
      MODE_SHORT_ABSOLUTE: begin
        eff_addr = {{(ADDR_W-SHORT_ADDR_W){1'b0}},
                    state_reg.addr_field[SHORT_ADDR_W-1:0]};
      end
      MODE_SHORT_IO: begin
        eff_addr = IO_REGION_BASE
                 | {{(ADDR_W-SHORT_ADDR_W){1'b0}},
                    state_reg.addr_field[SHORT_ADDR_W-1:0]};
      end
      MODE_POINTER_INDEXED: begin
        eff_addr = index_ptr_i + state_reg.addr_field;
      end
      MODE_STACK_RELATIVE: begin
        eff_addr = stack_ptr_i - state_reg.addr_field;
      end
      default: begin
        eff_addr = state_reg.addr_field;
      end
    endcase
    is_long = (state_reg.mode == MODE_POINTER_INDEXED)
            | (state_reg.mode == MODE_STACK_RELATIVE)
            | (state_reg.mode == MODE_LONG_ABSOLUTE);

    state_word = 32'h0000_0000;
    state_word[ST_BUSY_BIT] = (state_reg.eng != ENG_IDLE);
    state_word[ST_ILLEGAL_BIT] = state_reg.illegal;
    state_word[ST_DONE_BIT] = state_reg.done;
    state_word[ST_CYC_LSB +: 4] = state_reg.cost_cycles;
    state_word[ST_WORDS_LSB +: 2] = state_reg.cost_words;
    state_word[ST_DATA_LSB +: DATA_W] = state_reg.result;

    // Wishbone slave: ack one cycle after the request, dropped the cycle after.
    state_next.ack = req & ~state_reg.ack;
    if (req & ~state_reg.ack) begin
      unique case (wb_adr_i)
        CMD_OFS: begin
          state_next.rdata = {16'h0000, 6'h00,
                              state_reg.sel, 1'b0, state_reg.set_variant,
                              state_reg.mode};
        end
        MASK_OFS:   state_next.rdata = {16'h0000, state_reg.mask};
        ADDR_OFS:   state_next.rdata = {16'h0000, state_reg.addr_field};
        STATUS_OFS: state_next.rdata = {16'h0000, state_reg.status_word};
        STATE_OFS:  state_next.rdata = state_word;
        default:    state_next.rdata = 32'h0000_0000;
      endcase
    end

    // Writes take effect at the edge where the master sees ack.
    if (req & state_reg.ack & wb_we_i) begin
      unique case (wb_adr_i)
        CMD_OFS: begin
          wmerge = lane_merge({16'h0000, 6'h00, state_reg.sel, 1'b0,
                               state_reg.set_variant, state_reg.mode},
                              wb_dat_i, wb_sel_i);
          // Command fields are frozen while an operation runs.
          if (state_reg.eng == ENG_IDLE) begin
            state_next.mode = dest_mode_t'(wmerge[CMD_MODE_LSB +: 3]);
            state_next.set_variant = wmerge[CMD_SET_BIT];
            state_next.sel = wmerge[CMD_SEL_LSB +: REGSEL_W];
          end
        end
        MASK_OFS: begin
          wmerge = lane_merge({16'h0000, state_reg.mask}, wb_dat_i, wb_sel_i);
          if (state_reg.eng == ENG_IDLE) begin
            state_next.mask = wmerge[DATA_W-1:0];
          end
        end
        ADDR_OFS: begin
          wmerge = lane_merge({16'h0000, state_reg.addr_field}, wb_dat_i, wb_sel_i);
          if (state_reg.eng == ENG_IDLE) begin
            state_next.addr_field = wmerge[ADDR_W-1:0];
          end
        end
        STATUS_OFS: begin
          wmerge = lane_merge({16'h0000, state_reg.status_word}, wb_dat_i, wb_sel_i);
          state_next.status_word = wmerge[DATA_W-1:0];
        end
        default: begin
          wmerge = 32'h0000_0000;
        end
      endcase
    end

    state_next.mem_rd = 1'b0;
    state_next.mem_wr = 1'b0;
    state_next.rf_rd = 1'b0;
    state_next.rf_wr = 1'b0;
    operand = (state_reg.mode == MODE_ANY_REGISTER_OPERAND) ? rf_rdata_i : mem_rdata_i;
    // Legality is judged on the mode of the go write itself, not the stored one.
    legal_mode = (wmerge[CMD_MODE_LSB +: 3] <= MODE_LONG_ABSOLUTE);

    unique case (state_reg.eng)
      ENG_IDLE: begin
        // The go bit is a strobe; it needs a write with byte lane 0 selected.
        if (req & state_reg.ack & wb_we_i & (wb_adr_i == CMD_OFS)
            & wb_sel_i[0] & wb_dat_i[CMD_GO_BIT]) begin
          state_next.done = 1'b0;
          if (!legal_mode
              || ((wmerge[CMD_MODE_LSB +: 3] == MODE_ANY_REGISTER_OPERAND)
                  && (wmerge[CMD_SEL_LSB +: REGSEL_W] == HW_LOOP_STACK_SEL))) begin
            state_next.illegal = 1'b1;
          end else begin
            state_next.illegal = 1'b0;
            state_next.eng = ENG_READ;
          end
        end
      end
      ENG_READ: begin
        // Operands are latched now so a bus write cannot tear the access.
        state_next.cost_cycles = is_long ? CYC_LONG : CYC_SHORT;
        state_next.cost_words = (state_reg.mode == MODE_LONG_ABSOLUTE)
                              ? WORDS_THREE : WORDS_TWO;
        state_next.stall_left = (is_long ? CYC_LONG : CYC_SHORT) - CYC_FIXED;
        state_next.dest_addr = eff_addr;
        if (state_reg.mode == MODE_ANY_REGISTER_OPERAND) begin
          state_next.rf_rd = 1'b1;
        end else begin
          state_next.mem_rd = 1'b1;
        end
        state_next.eng = ENG_CAPTURE;
      end
      ENG_CAPTURE: begin
        state_next.carry = field_all_ones(operand, state_reg.mask);
        state_next.result = field_modify(operand, state_reg.mask,
                                         state_reg.set_variant);
        state_next.limited = (state_reg.mode == MODE_ANY_REGISTER_OPERAND)
                           & rf_limited_i;
        state_next.stall_left = state_reg.stall_left - 4'h1;
        state_next.eng = (state_reg.stall_left == 4'h1) ? ENG_WRITE : ENG_STALL;
      end
      ENG_STALL: begin
        state_next.stall_left = state_reg.stall_left - 4'h1;
        state_next.eng = (state_reg.stall_left == 4'h1) ? ENG_WRITE : ENG_STALL;
      end
      ENG_WRITE: begin
        // Engine flag update wins over a concurrent software write.
        state_next.status_word[CARRY_BIT] = state_reg.carry;
        if (state_reg.limited) begin
          state_next.status_word[LIMIT_BIT] = 1'b1;
        end
        if (state_reg.mode == MODE_ANY_REGISTER_OPERAND) begin
          state_next.rf_wr = 1'b1;
        end else begin
          state_next.mem_wr = 1'b1;
        end
        state_next.done = 1'b1;
        state_next.eng = ENG_IDLE;
      end
      default: begin
        state_next.eng = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= '{ack: 1'b0, rdata: 32'h0000_0000,
                     mode: MODE_ANY_REGISTER_OPERAND, set_variant: 1'b0,
                     sel: 5'h00, mask: 16'h0000, addr_field: 16'h0000,
                     status_word: STATUS_RESET, eng: ENG_IDLE,
                     stall_left: 4'h0, cost_cycles: 4'h0, cost_words: 2'h0,
                     illegal: 1'b0, done: 1'b0, dest_addr: 16'h0000,
                     result: 16'h0000, carry: 1'b0, limited: 1'b0,
                     mem_rd: 1'b0, mem_wr: 1'b0, rf_rd: 1'b0, rf_wr: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o    = state_reg.ack;
  assign wb_dat_o    = state_reg.rdata;
  assign mem_addr_o  = state_reg.dest_addr;
  assign mem_rd_o    = state_reg.mem_rd;
  assign mem_wr_o    = state_reg.mem_wr;
  assign mem_wdata_o = state_reg.result;
  assign rf_sel_o    = state_reg.sel;
  assign rf_rd_o     = state_reg.rf_rd;
  assign rf_wr_o     = state_reg.rf_wr;
  assign rf_wdata_o  = state_reg.result;

endmodule // bitfield_test_and_modify

// ---- tb/bitfield_partner.sv ----
// Behavioural data memory, peripheral space and core register file.
// Assumes the engine samples read data at the edge that ends its read strobe.
module bitfield_partner
  import bitfield_pkg::*;
(
  input  wire logic                          sys_clk_i,
  input  wire logic [bitfield_pkg::ADDR_W-1:0] mem_addr_i,
  input  wire logic                          mem_rd_i,
  input  wire logic                          mem_wr_i,
  input  wire logic [bitfield_pkg::DATA_W-1:0] mem_wdata_i,
  output logic      [bitfield_pkg::DATA_W-1:0] mem_rdata_o,
  input  wire logic [bitfield_pkg::REGSEL_W-1:0] rf_sel_i,
  input  wire logic                          rf_rd_i,
  input  wire logic                          rf_wr_i,
  input  wire logic [bitfield_pkg::DATA_W-1:0] rf_wdata_i,
  output logic      [bitfield_pkg::DATA_W-1:0] rf_rdata_o,
  output logic                               rf_limited_o,
  input  wire logic                          limit_req_i
);
  logic [DATA_W-1:0] mem [0:65535];
  logic [DATA_W-1:0] rf [0:31];
  logic [DATA_W-1:0] mem_idle = 16'h0000;
  logic [DATA_W-1:0] rf_idle  = 16'h0000;

  // Outside a read the data lines toggle, so a late or early sample shows up.
  assign mem_rdata_o  = mem_rd_i ? mem[mem_addr_i] : mem_idle;
  assign rf_rdata_o   = rf_rd_i ? rf[rf_sel_i] : rf_idle;
  assign rf_limited_o = rf_rd_i && limit_req_i;

  always @(posedge sys_clk_i) begin
    mem_idle <= ~mem_idle;
    rf_idle <= ~rf_idle;
    if (mem_wr_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
    if (rf_wr_i) begin
      rf[rf_sel_i] <= rf_wdata_i;
    end
  end
endmodule // bitfield_partner

// ---- tb/bitfield_checker.sv ----
// Port-level timing and data checks for the bit-field engine.
// Assumes it is bound to the engine's top module; one clock domain.
module bitfield_checker
  import bitfield_pkg::*;
(
  input wire logic                            sys_clk_i,
  input wire logic                            rst_b_i,
  input wire logic                            wb_cyc_i,
  input wire logic                            wb_stb_i,
  input wire logic                            wb_we_i,
  input wire logic [bitfield_pkg::WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]                      wb_sel_i,
  input wire logic [31:0]                     wb_dat_i,
  input wire logic                            wb_ack_o,
  input wire logic [bitfield_pkg::ADDR_W-1:0]   mem_addr_o,
  input wire logic                            mem_rd_o,
  input wire logic                            mem_wr_o,
  input wire logic [bitfield_pkg::DATA_W-1:0]   mem_wdata_o,
  input wire logic [bitfield_pkg::DATA_W-1:0]   mem_rdata_i,
  input wire logic [bitfield_pkg::REGSEL_W-1:0] rf_sel_o,
  input wire logic                            rf_rd_o,
  input wire logic                            rf_wr_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  dest_mode_t  mode_q;
  logic [15:0] cap_q;
  logic        go_w;
  assign go_w = wb_ack_o && wb_cyc_i && wb_we_i && wb_adr_i == CMD_OFS && wb_sel_i[0]
                && wb_dat_i[CMD_GO_BIT];

  // Remember the mode of the last go and the word the engine read back.
  always_ff @(posedge sys_clk_i) begin
    if (go_w) begin
      mode_q <= dest_mode_t'(wb_dat_i[2:0]);
    end
    if (mem_rd_o) begin
      cap_q <= mem_rdata_i;
    end
  end

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_b_i |=> !(wb_ack_o || mem_rd_o || mem_wr_o || rf_rd_o || rf_wr_o))
    else $error("strobe active after reset");
  short_cost_a: assert property (mem_rd_o && (mode_q == MODE_SHORT_ABSOLUTE
    || mode_q == MODE_SHORT_IO) |-> ##2 mem_wr_o) else $error("short write-back late");
  long_cost_a: assert property (mem_rd_o && mode_q inside {MODE_POINTER_INDEXED,
    MODE_STACK_RELATIVE, MODE_LONG_ABSOLUTE} |=> !mem_wr_o [*3] ##1 mem_wr_o)
    else $error("long write-back not at sixth cycle");
  reg_cost_a: assert property (rf_rd_o |-> ##2 (rf_wr_o && rf_sel_o == $past(rf_sel_o, 2)))
    else $error("register write-back wrong");
  field_dir_a: assert property (mem_wr_o |-> (mem_wdata_o & ~cap_q) == 16'h0000
    || (cap_q & ~mem_wdata_o) == 16'h0000) else $error("bits changed both ways");
  abs_range_a: assert property (mem_rd_o && mode_q == MODE_SHORT_ABSOLUTE
    |-> mem_addr_o[15:6] == 10'h000) else $error("short address above 6 bits");
  io_region_a: assert property (mem_rd_o && mode_q == MODE_SHORT_IO
    |-> mem_addr_o[15:6] == IO_REGION_BASE[15:6]) else $error("io address outside region");
  addr_hold_a: assert property (mem_rd_o |=> $stable(mem_addr_o) [*3])
    else $error("address moved before write-back");
  stack_refused_a: assert property (go_w && wb_dat_i[2:0] == 3'h0
    && wb_dat_i[9:5] == HW_LOOP_STACK_SEL |=> !rf_rd_o [*4]) else $error("loop stack accessed");

  cover property (mem_rd_o && mode_q == MODE_SHORT_IO ##2 mem_wr_o);
  cover property (mem_rd_o && mode_q == MODE_LONG_ABSOLUTE ##4 mem_wr_o);
  cover property (rf_rd_o ##2 rf_wr_o);
endmodule // bitfield_checker

bind bitfield_test_and_modify bitfield_checker chk_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
  .mem_rdata_i(mem_rdata_i), .rf_sel_o(rf_sel_o), .rf_rd_o(rf_rd_o), .rf_wr_o(rf_wr_o));

// ---- tb/bitfield_test_and_modify_tb.sv ----
// Self-checking bench: every destination mode, flags, refusals and reset.
// Assumes the partner model on the far side and the bound checker.
module bitfield_test_and_modify_tb
  import bitfield_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [2:0]  m;
    logic        s;
    logic [4:0]  rs;
    logic [15:0] mk;
    logic [15:0] a;
    logic [15:0] init;
  } row_t;

  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        lim = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, wb_dat;
  logic [15:0] iptr = 16'h1000, sptr = 16'h2000, dst, ex, got, maddr, mwd, mrd, rwd, rrd;
  logic [4:0]  rsel;
  logic        ack, mrd_s, mwr_s, rrd_s, rwr_s, rlim;
  row_t        r;
  int          mismatches = 0;
  int          cmp_count = 0;
  row_t rows [8] = '{
    '{3'h2, 1'b0, 5'h00, 16'h0310, 16'h0022, 16'h7F95},
    '{3'h2, 1'b1, 5'h00, 16'hF400, 16'h0022, 16'h8921},
    '{3'h1, 1'b0, 5'h00, 16'h0000, 16'hFF7F, 16'h1234},
    '{3'h0, 1'b1, 5'h03, 16'h00FF, 16'h0000, 16'h00FF},
    '{3'h3, 1'b0, 5'h00, 16'hFFFF, 16'h0010, 16'hFFFF},
    '{3'h4, 1'b1, 5'h00, 16'h8001, 16'h0004, 16'h0001},
    '{3'h5, 1'b0, 5'h00, 16'h0F0F, 16'hABCD, 16'h0F0F},
    '{3'h0, 1'b1, 5'h00, 16'hFFFF, 16'h0000, 16'h0000}};

  always #50 sys_clk = ~sys_clk;

  bitfield_test_and_modify dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat), .wb_ack_o(ack), .index_ptr_i(iptr), .stack_ptr_i(sptr),
    .mem_addr_o(maddr), .mem_rd_o(mrd_s), .mem_wr_o(mwr_s), .mem_wdata_o(mwd),
    .mem_rdata_i(mrd), .rf_sel_o(rsel), .rf_rd_o(rrd_s), .rf_wr_o(rwr_s), .rf_wdata_o(rwd),
    .rf_rdata_i(rrd), .rf_limited_i(rlim));
  bitfield_partner part_u (.sys_clk_i(sys_clk), .mem_addr_i(maddr), .mem_rd_i(mrd_s),
    .mem_wr_i(mwr_s), .mem_wdata_i(mwd), .mem_rdata_o(mrd), .rf_sel_i(rsel), .rf_rd_i(rrd_s),
    .rf_wr_i(rwr_s), .rf_wdata_i(rwd), .rf_rdata_o(rrd), .rf_limited_o(rlim),
    .limit_req_i(lim));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release.
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rdat = wb_dat;
    {cyc, stb} <= 2'b00;
    if (n >= 16) chk("wb_ack", 32'h1, 32'h0);
  endtask

  task automatic run(input logic [2:0] m, input logic s, input logic [4:0] rs,
                     input logic [15:0] mk, input logic [15:0] a);
    int n;
    n = 0;
    wbx(1'b1, MASK_OFS, {16'h0, mk});
    wbx(1'b1, ADDR_OFS, {16'h0, a});
    wbx(1'b1, CMD_OFS, {22'h0, rs, 1'b1, s, m});
    do begin
      wbx(1'b0, STATE_OFS, 32'h0);
      n++;
    end while (rdat[ST_BUSY_BIT] !== 1'b0 && n < 16);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      case (r.m)
        3'h1: dst = {10'h000, r.a[5:0]};
        3'h2: dst = IO_REGION_BASE | {10'h000, r.a[5:0]};
        3'h3: dst = iptr + r.a;
        3'h4: dst = sptr - r.a;
        default: dst = r.a;
      endcase
      if (r.m == 3'h0) part_u.rf[r.rs] = r.init;
      else part_u.mem[dst] = r.init;
      run(r.m, r.s, r.rs, r.mk, r.a);
      ex = r.s ? (r.init | r.mk) : (r.init & ~r.mk);
      got = (r.m == 3'h0) ? part_u.rf[r.rs] : part_u.mem[dst];
      chk("dest_word", {16'h0, ex}, {16'h0, got});
      chk("result", {16'h0, ex}, {16'h0, rdat[31:16]});
      chk("cost", {(r.m > 3'h2) ? CYC_LONG : CYC_SHORT, (r.m == 3'h5) ? WORDS_THREE
          : WORDS_TWO, 1'b1}, {rdat[7:4], rdat[9:8], rdat[ST_DONE_BIT]});
      wbx(1'b0, STATUS_OFS, 32'h0);
      chk("status", {31'h0, (r.init & r.mk) == r.mk}, rdat);
    end
    part_u.rf[2] = 16'h0000;
    wbx(1'b1, STATUS_OFS, 32'h0000AAAA);
    lim <= 1'b1;
    run(3'h0, 1'b0, 5'h02, 16'h0000, 16'h0000);
    lim <= 1'b0;
    wbx(1'b0, STATUS_OFS, 32'h0);
    chk("status_limit", 32'h0000AAEB, rdat);
    part_u.rf[31] = 16'h5A5A;
    for (int k = 0; k < 3; k++) begin
      run((k == 0) ? 3'h0 : 3'(5 + k), 1'b0, HW_LOOP_STACK_SEL, 16'hFFFF, 16'h0000);
      chk("illegal", 32'h2, {30'h0, rdat[ST_ILLEGAL_BIT], rdat[ST_BUSY_BIT]});
      chk("stack_reg", 32'h5A5A, {16'h0, part_u.rf[31]});
    end
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    wbx(1'b1, 8'h14, 32'hFFFFFFFF);
    for (int k = 0; k < 6; k++) begin
      wbx(1'b0, 8'(4 * k), 32'h0);
      chk("reset_reg", 32'h0, rdat);
    end
    report_and_stop();
  end
endmodule // bitfield_test_and_modify_tb
